/* ttms_pkg.sv */
// Package of constants and types for the tape transport motion sequencer.
package ttms_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int SEL_W = 3;
    localparam int MDC_W = 15;
    localparam int SDC_W = 4;
    localparam int FC_W = 16;
    localparam logic [SDC_W-1:0] SDC_LIMIT = 4'hF;
    localparam logic [1:0] MDC_TOP_PRESET = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint GAP_TIME_US = 2700;
    localparam longint GAP_CYCLES = (GAP_TIME_US * CLK_HZ) / 1000000;
    localparam longint OPI_TIME_S = 7;
    localparam longint OPI_CYCLES = OPI_TIME_S * CLK_HZ;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TTMS_OP_READ = 3'h0,
        TTMS_OP_WRITE = 3'h1,
        TTMS_OP_ERASE = 3'h2,
        TTMS_OP_SPACE = 3'h3,
        TTMS_OP_REWIND = 3'h4,
        TTMS_OP_WTM = 3'h5
    } ttms_op_e;

    // Sequence states, Gray-coded in declaration order; the path from TTMS_RUN back through TTMS_LOAD to TTMS_DECEL is not.
    typedef enum logic [2:0] {
        TTMS_IDLE = 3'h0,
        TTMS_LOAD = 3'h1,
        TTMS_ACCEL = 3'h3,
        TTMS_RUN = 3'h2,
        TTMS_DECEL = 3'h6,
        TTMS_STOPPED = 3'h7
    } ttms_state_e;

endpackage : ttms_pkg

/* ttms_sync.sv */
// Two-flop synchroniser bank with an edge pulse on the synchronised level.
`timescale 1ns/100ps
module ttms_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
    } ttms_sync_s;

    ttms_sync_s q;
    ttms_sync_s next_q;

    always_comb
    begin
        next_q.meta = async_i;
        next_q.sync = q.meta;
        next_q.last = q.sync;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign level_o = q.sync;
    assign rise_o = q.sync & ~q.last;

endmodule : ttms_sync

/* ttms_counter.sv */
// Loadable up counter with synchronous clear, count enable and carry out.
`timescale 1ns/100ps
module ttms_counter #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_value_i,
    input wire logic count_i,
    output logic [WIDTH-1:0] value_o,
    output logic carry_o
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } ttms_counter_s;

    ttms_counter_s q;
    ttms_counter_s next_q;

    always_comb
    begin
        next_q = q;
        if (clear_i)
            next_q.value = '0;
        else if (load_i)
            next_q.value = load_value_i;
        else if (count_i)
            next_q.value = q.value + WIDTH'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            q <= '0;
        else
            q <= next_q;
    end

    assign value_o = q.value;
    assign carry_o = count_i && !clear_i && !load_i && (&q.value);

endmodule : ttms_counter

/* ttms_sequencer.sv */
// Tape motion sequencer: selection, start delay, stop sequences and timeout.
`timescale 1ns/100ps
module ttms_sequencer #(
    parameter int MDC_W = ttms_pkg::MDC_W,
    parameter int FC_W = ttms_pkg::FC_W,
    parameter longint GAP_CYCLES = ttms_pkg::GAP_CYCLES,
    parameter longint OPI_CYCLES = ttms_pkg::OPI_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ttms_pkg::SEL_W-1:0] unit_i,
    input wire logic run_request_i,
    input wire logic go_request_i,
    input wire logic [2:0] op_i,
    input wire logic reverse_i,
    input wire logic [FC_W-1:0] frame_count_i,
    input wire logic [MDC_W-1:0] preset_data_i,
    input wire logic clk800_i,
    input wire logic clk200_i,
    input wire logic envelope_present_i,
    input wire logic nrzi_data_pulse_i,
    input wire logic record_detected_i,
    input wire logic tape_mark_i,
    input wire logic write_clock_gate_i,
    input wire logic slowing_down_status_i,
    input wire logic rewinding_status_i,
    input wire logic slave_status_change_i,
    input wire logic transport_ready_status_i,
    output logic transport_select_bit0_o,
    output logic transport_select_bit1_o,
    output logic transport_select_bit2_o,
    output logic transport_go_pulse_o,
    output logic motion_delay_load_o,
    output logic stop_o,
    output logic forward_command_o,
    output logic reverse_command_o,
    output logic rewind_command_o,
    output logic write_command_o,
    output logic accelerating_flag_o,
    output logic decelerating_flag_o,
    output logic reading_active_o,
    output logic end_of_record_pulse_o,
    output logic operation_incomplete_error_o,
    output logic attention_request_o,
    output logic [FC_W-1:0] frame_count_o,
    output logic busy_o
);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] s_lvl;
    logic [NSYNC-1:0] s_rise;

    ttms_sync #(.WIDTH(NSYNC)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({clk800_i, clk200_i, envelope_present_i,
                  nrzi_data_pulse_i, write_clock_gate_i,
                  slowing_down_status_i, rewinding_status_i,
                  slave_status_change_i, transport_ready_status_i}),
        .level_o(s_lvl),
        .rise_o(s_rise)
    );

    logic tick800;
    logic tick200;
    logic data_seen;
    logic wr_gate;
    logic sdwn_rise;
    assign tick800 = s_rise[8];
    assign tick200 = s_rise[7];
    assign data_seen = s_lvl[6] | s_lvl[5];
    assign wr_gate = s_lvl[4];
    assign sdwn_rise = s_rise[3];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ttms_pkg::ttms_state_e state;
        logic [2:0] op;
        logic reverse;
        logic go;
        logic load;
        logic stop;
        logic accl;
        logic stopping;
        logic armed;
        logic operation_incomplete_error;
        logic attention_request;
        logic eor;
        logic space_done;
        logic [FC_W-1:0] fc;
        logic [31:0] gap_cnt;
        logic [31:0] opi_cnt;
    } ttms_seq_s;

    ttms_seq_s q;
    ttms_seq_s next_q;

    function automatic logic is_data_op(input logic [2:0] op);
        return op == 3'(ttms_pkg::TTMS_OP_READ)
            || op == 3'(ttms_pkg::TTMS_OP_WRITE);
    endfunction : is_data_op

    function automatic logic is_timed_op(input logic [2:0] op);
        return is_data_op(op) || op == 3'(ttms_pkg::TTMS_OP_SPACE);
    endfunction : is_timed_op

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    logic [MDC_W-1:0] mdc_val;
    logic mdc_carry;
    logic mdc_load;
    logic [MDC_W-1:0] mdc_preset;
    logic mdc_count;
    logic [ttms_pkg::SDC_W-1:0] sdc_val;
    logic sdc_clear;
    logic sdc_count;
    logic sdc_done;

    assign mdc_load = q.load;
    assign mdc_preset = q.stopping
        ? {ttms_pkg::MDC_TOP_PRESET, preset_data_i[MDC_W-3:0]}
        : preset_data_i;
    assign mdc_count = tick800 && !q.load
        && (q.state == ttms_pkg::TTMS_ACCEL
            || q.state == ttms_pkg::TTMS_DECEL);

    ttms_counter #(.WIDTH(MDC_W)) u_mdc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .clear_i(1'b0),
        .load_i(mdc_load),
        .load_value_i(mdc_preset),
        .count_i(mdc_count),
        .value_o(mdc_val),
        .carry_o(mdc_carry)
    );

    assign sdc_clear = q.state != ttms_pkg::TTMS_RUN
        || data_seen;
    assign sdc_count = tick200 && (q.armed || q.operation_incomplete_error)
        && q.gap_cnt == 32'h0 && !sdc_done;
    assign sdc_done = sdc_val == ttms_pkg::SDC_LIMIT;

    ttms_counter #(.WIDTH(ttms_pkg::SDC_W)) u_sdc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .clear_i(sdc_clear),
        .load_i(1'b0),
        .load_value_i('0),
        .count_i(sdc_count),
        .value_o(sdc_val),
        .carry_o()
    );

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    logic drive_req;
    assign drive_req = run_request_i
        ? is_data_op(op_i) : (go_request_i && !is_data_op(op_i));

    always_comb
    begin
        next_q = q;
        next_q.go = 1'b0;
        next_q.load = 1'b0;
        next_q.eor = 1'b0;
        next_q.attention_request = 1'b0;
        if (q.gap_cnt != 32'h0)
            next_q.gap_cnt = q.gap_cnt - 32'h1;
        if (wr_gate)
            next_q.gap_cnt = 32'(GAP_CYCLES);
        if (q.state == ttms_pkg::TTMS_ACCEL || q.state == ttms_pkg::TTMS_RUN)
        begin
            if (is_timed_op(q.op) && q.opi_cnt != 32'h0)
                next_q.opi_cnt = q.opi_cnt - 32'h1;
            if (is_timed_op(q.op) && q.opi_cnt == 32'h1)
                next_q.operation_incomplete_error = 1'b1;
        end
        case (q.state)
            ttms_pkg::TTMS_IDLE, ttms_pkg::TTMS_STOPPED:
            begin
                if (drive_req && !(q.state == ttms_pkg::TTMS_STOPPED
                                   && q.op == 3'(ttms_pkg::TTMS_OP_SPACE)))
                begin
                    next_q.op = op_i;
                    next_q.reverse = reverse_i;
                    next_q.stop = 1'b0;
                    next_q.go = 1'b1;
                    next_q.load = 1'b1;
                    next_q.accl = 1'b1;
                    next_q.stopping = 1'b0;
                    next_q.armed = 1'b0;
                    next_q.operation_incomplete_error = 1'b0;
                    next_q.space_done = 1'b0;
                    next_q.fc = frame_count_i;
                    next_q.opi_cnt = 32'(OPI_CYCLES);
                    next_q.state = ttms_pkg::TTMS_LOAD;
                    if (op_i == 3'(ttms_pkg::TTMS_OP_REWIND))
                        next_q.attention_request = 1'b1;
                end
                else if (q.state == ttms_pkg::TTMS_STOPPED
                         && q.op == 3'(ttms_pkg::TTMS_OP_SPACE)
                         && sdwn_rise)
                begin
                    // stop on overflow, tape mark or operation incomplete timeout
                    if (q.space_done || q.operation_incomplete_error)
                    begin
                        next_q.attention_request = 1'b1;
                        next_q.state = ttms_pkg::TTMS_IDLE;
                    end
                    else
                    begin
                        next_q.stop = 1'b0;
                        next_q.go = 1'b1;
                        next_q.load = 1'b1;
                        next_q.accl = 1'b1;
                        next_q.stopping = 1'b0;
                        next_q.armed = 1'b0;
                        next_q.state = ttms_pkg::TTMS_LOAD;
                    end
                end
            end
            ttms_pkg::TTMS_LOAD:
            begin
                if (q.op == 3'(ttms_pkg::TTMS_OP_REWIND))
                begin
                    next_q.stop = 1'b1;
                    next_q.accl = 1'b0;
                    next_q.state = ttms_pkg::TTMS_IDLE;
                end
                else
                    next_q.state = q.stopping
                        ? ttms_pkg::TTMS_DECEL : ttms_pkg::TTMS_ACCEL;
            end
            ttms_pkg::TTMS_ACCEL:
            begin
                if (mdc_val[MDC_W-1])
                begin
                    next_q.accl = 1'b0;
                    next_q.state = ttms_pkg::TTMS_RUN;
                    if (q.op == 3'(ttms_pkg::TTMS_OP_ERASE))
                        next_q.armed = 1'b1;
                end
            end
            ttms_pkg::TTMS_RUN:
            begin
                if (record_detected_i || tape_mark_i)
                begin
                    next_q.armed = 1'b1;
                    if (q.op == 3'(ttms_pkg::TTMS_OP_SPACE)
                        && !q.armed)
                    begin
                        next_q.fc = q.fc + FC_W'(1);
                        if (tape_mark_i || &q.fc)
                            next_q.space_done = 1'b1;
                    end
                end
                // end of record and stop delay
                if (sdc_done)
                begin
                    next_q.eor = 1'b1;
                    next_q.load = 1'b1;
                    next_q.stopping = 1'b1;
                    next_q.state = ttms_pkg::TTMS_LOAD;
                end
            end
            ttms_pkg::TTMS_DECEL:
            begin
                if (mdc_carry)
                begin
                    next_q.accl = 1'b1;
                    next_q.stop = 1'b1;
                    next_q.state = ttms_pkg::TTMS_STOPPED;
                    if (q.op == 3'(ttms_pkg::TTMS_OP_ERASE)
                        || q.op == 3'(ttms_pkg::TTMS_OP_WTM))
                        next_q.attention_request = 1'b1;
                end
            end
            default:
                next_q.state = ttms_pkg::TTMS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
            q.stop <= 1'b1;
        end
        else
            q <= next_q;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // one select code
    assign transport_select_bit0_o = unit_i[0];
    assign transport_select_bit1_o = unit_i[1];
    assign transport_select_bit2_o = unit_i[2];
    assign transport_go_pulse_o = q.go;
    assign motion_delay_load_o = q.load;
    assign stop_o = q.stop;
    assign forward_command_o = q.state != ttms_pkg::TTMS_IDLE
        && !q.reverse && q.op != 3'(ttms_pkg::TTMS_OP_REWIND);
    assign reverse_command_o = q.state != ttms_pkg::TTMS_IDLE
        && q.reverse && q.op != 3'(ttms_pkg::TTMS_OP_REWIND);
    assign rewind_command_o = q.go && q.op == 3'(ttms_pkg::TTMS_OP_REWIND);
    assign write_command_o = q.state != ttms_pkg::TTMS_IDLE
        && (q.op == 3'(ttms_pkg::TTMS_OP_WRITE)
            || q.op == 3'(ttms_pkg::TTMS_OP_ERASE)
            || q.op == 3'(ttms_pkg::TTMS_OP_WTM));
    assign accelerating_flag_o = q.accl;
    assign decelerating_flag_o = q.state == ttms_pkg::TTMS_DECEL;
    assign reading_active_o = q.state == ttms_pkg::TTMS_RUN;
    assign end_of_record_pulse_o = q.eor;
    assign operation_incomplete_error_o = q.operation_incomplete_error;
    assign attention_request_o = q.attention_request;
    assign frame_count_o = q.fc;
    assign busy_o = q.state != ttms_pkg::TTMS_IDLE;

endmodule : ttms_sequencer

/* ttms_sequencer_properties.sv */
// Port-level concurrent checks for the tape transport motion sequencer.
`timescale 1ns/100ps
module ttms_sequencer_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ttms_pkg::SEL_W-1:0] unit_i,
    input wire logic run_request_i,
    input wire logic go_request_i,
    input wire logic [2:0] op_i,
    input wire logic transport_select_bit0_o,
    input wire logic transport_select_bit1_o,
    input wire logic transport_select_bit2_o,
    input wire logic transport_go_pulse_o,
    input wire logic motion_delay_load_o,
    input wire logic stop_o,
    input wire logic rewind_command_o,
    input wire logic accelerating_flag_o,
    input wire logic decelerating_flag_o,
    input wire logic reading_active_o,
    input wire logic end_of_record_pulse_o,
    input wire logic operation_incomplete_error_o,
    input wire logic attention_request_o,
    input wire logic busy_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    AST_SELECT: assert property ({transport_select_bit2_o,
        transport_select_bit1_o, transport_select_bit0_o} == unit_i)
        else $error("select lines differ from unit number");
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !rstn_i |=> stop_o && !transport_go_pulse_o && !motion_delay_load_o)
        else $error("outputs not in reset state");
    AST_RUN_START: assert property (run_request_i && !busy_o
        && op_i < 3'h2 |=> transport_go_pulse_o && motion_delay_load_o
        && !stop_o) else $error("run request did not start motion");
    AST_FUNC_START: assert property (go_request_i && !busy_o
        && op_i >= 3'h2 && op_i <= 3'h5 |=> transport_go_pulse_o)
        else $error("function request did not start motion");
    AST_GO_ONE_CYCLE: assert property (transport_go_pulse_o
        |=> !transport_go_pulse_o) else $error("go pulse too long");
    AST_STOP_RELEASE: assert property ($fell(stop_o)
        |-> transport_go_pulse_o) else $error("stop dropped without go");
    AST_REWIND_STOP: assert property (transport_go_pulse_o
        && rewind_command_o |=> stop_o) else $error("rewind left stop low");
    AST_REWIND_ATTENTION_REQUEST: assert property (transport_go_pulse_o
        && rewind_command_o |-> attention_request_o)
        else $error("no attention on rewind start");
    AST_READ_GATE: assert property (reading_active_o
        |-> !accelerating_flag_o && !decelerating_flag_o)
        else $error("reading while accelerating or decelerating");
    AST_EOR_RELOAD: assert property (end_of_record_pulse_o
        |-> ##[0:1] motion_delay_load_o) else $error("no stop delay load");
    AST_DECEL_END: assert property ($fell(decelerating_flag_o)
        |-> ##[0:1] (accelerating_flag_o && stop_o))
        else $error("stop delay end did not raise stop");

    COV_EOR: cover property (end_of_record_pulse_o);
    COV_OPI: cover property ($rose(operation_incomplete_error_o));
    COV_REWIND: cover property (transport_go_pulse_o && rewind_command_o);
    COV_ATTENTION_REQUEST: cover property (attention_request_o && !rewind_command_o);
endmodule : ttms_sequencer_properties

bind ttms_sequencer ttms_sequencer_properties props (.clk_i, .rstn_i,
    .unit_i, .run_request_i, .go_request_i, .op_i, .transport_select_bit0_o,
    .transport_select_bit1_o, .transport_select_bit2_o,
    .transport_go_pulse_o, .motion_delay_load_o, .stop_o, .rewind_command_o,
    .accelerating_flag_o, .decelerating_flag_o, .reading_active_o,
    .end_of_record_pulse_o, .operation_incomplete_error_o,
    .attention_request_o, .busy_o);

/* ttms_transport_model.sv */
// Behavioural model of one tape transport on the shared transport bus.
`timescale 1ns/100ps
module ttms_transport_model #(
    parameter logic [2:0] UNIT = 3'h5
) (
    input wire logic clk_i,
    input wire logic [2:0] sel_i,
    input wire logic go_i,
    input wire logic load_i,
    input wire logic stop_i,
    input wire logic rewind_i,
    input wire logic write_i,
    input wire logic accl_i,
    input wire logic [1:0] mode_i,
    output logic [14:0] preset_o,
    output logic clk800_o,
    output logic clk200_o,
    output logic env_o,
    output logic nrzi_o,
    output logic rec_o,
    output logic tm_o,
    output logic wgate_o,
    output logic sdwn_o,
    output logic rws_o,
    output logic ssc_o,
    output logic tur_o
);
    logic moving = 1'b0;
    logic [14:0] last = 15'h0000;
    int ph = 0;
    int dcnt = 60;
    int scnt = 0;
    int rcnt = 0;
    logic sel;
    logic data;

    assign sel = sel_i == UNIT;
    assign preset_o = (sel && load_i) ? (accl_i ? 15'h3FF0 : 15'h7FF0) : ~last;
    assign clk800_o = moving && ph[1];
    assign clk200_o = moving && ph[2];
    assign data = moving && dcnt > 0 && dcnt < 40;
    assign env_o = data && mode_i == 2'h1;
    assign nrzi_o = env_o && ph[0];
    assign rec_o = env_o && dcnt == 20;
    assign tm_o = data && mode_i == 2'h2 && dcnt == 20;
    assign wgate_o = data && write_i && !accl_i;
    assign sdwn_o = moving && stop_i && scnt < 8;
    assign rws_o = rcnt > 1;
    assign ssc_o = rcnt == 1;
    assign tur_o = !moving && rcnt == 0;

    always @(posedge clk_i)
    begin
        ph <= ph + 1;
        last <= preset_o;
        if (dcnt < 60 && moving && !accl_i)
            dcnt <= dcnt + 1;
        if (rcnt > 0)
            rcnt <= rcnt - 1;
        if (moving && stop_i)
            scnt <= scnt + 1;
        if (scnt == 8)
            moving <= 1'b0;
        if (sel && go_i)
        begin
            moving <= !rewind_i;
            rcnt <= rewind_i ? 30 : 0;
            dcnt <= 0;
            scnt <= 0;
        end
    end
endmodule : ttms_transport_model

/* ttms_sequencer_bench.sv */
// Self-checking testbench for the tape transport motion sequencer.
`timescale 1ns/100ps
module ttms_sequencer_bench;
    localparam logic [2:0] UNIT = 3'h5;
    localparam int GAP = 20;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] unit_i = UNIT;
    logic run_request_i = 1'b0;
    logic go_request_i = 1'b0;
    logic [2:0] op_i = 3'h0;
    logic reverse_i = 1'b0;
    logic [15:0] frame_count_i = 16'h0000;
    logic [1:0] rec_mode = 2'h0;
    logic [14:0] preset_data_i;
    logic clk800_i, clk200_i, envelope_present_i, nrzi_data_pulse_i;
    logic record_detected_i, tape_mark_i, write_clock_gate_i;
    logic slowing_down_status_i, rewinding_status_i, slave_status_change_i;
    logic transport_ready_status_i, transport_select_bit0_o;
    logic transport_select_bit1_o, transport_select_bit2_o;
    logic transport_go_pulse_o, motion_delay_load_o, stop_o, busy_o;
    logic forward_command_o, reverse_command_o, rewind_command_o;
    logic write_command_o, accelerating_flag_o, decelerating_flag_o;
    logic reading_active_o, end_of_record_pulse_o, attention_request_o;
    logic operation_incomplete_error_o;
    logic [15:0] frame_count_o;
    int miscompares = 0;
    int checks_done = 0;
    int go_seen = 0;
    time gate_fall = 0;
    time t0 = 0;

    always #20 clk_i = ~clk_i;

    // The timeout is shortened so that a missing end of record shows quickly.
    ttms_sequencer #(.OPI_CYCLES(2000), .GAP_CYCLES(GAP)) dut (.clk_i,
        .rstn_i, .unit_i, .run_request_i, .go_request_i, .op_i, .reverse_i,
        .frame_count_i, .preset_data_i, .clk800_i, .clk200_i,
        .envelope_present_i, .nrzi_data_pulse_i, .record_detected_i,
        .tape_mark_i, .write_clock_gate_i, .slowing_down_status_i,
        .rewinding_status_i, .slave_status_change_i, .transport_ready_status_i,
        .transport_select_bit0_o, .transport_select_bit1_o,
        .transport_select_bit2_o, .transport_go_pulse_o, .motion_delay_load_o,
        .stop_o, .forward_command_o, .reverse_command_o, .rewind_command_o,
        .write_command_o, .accelerating_flag_o, .decelerating_flag_o,
        .reading_active_o, .end_of_record_pulse_o, .attention_request_o,
        .operation_incomplete_error_o, .frame_count_o, .busy_o);

    ttms_transport_model #(.UNIT(UNIT)) partner (.clk_i,
        .sel_i({transport_select_bit2_o, transport_select_bit1_o,
        transport_select_bit0_o}), .go_i(transport_go_pulse_o),
        .load_i(motion_delay_load_o), .stop_i(stop_o),
        .rewind_i(rewind_command_o), .write_i(write_command_o),
        .accl_i(accelerating_flag_o), .mode_i(rec_mode),
        .preset_o(preset_data_i), .clk800_o(clk800_i), .clk200_o(clk200_i),
        .env_o(envelope_present_i), .nrzi_o(nrzi_data_pulse_i),
        .rec_o(record_detected_i), .tm_o(tape_mark_i),
        .wgate_o(write_clock_gate_i), .sdwn_o(slowing_down_status_i),
        .rws_o(rewinding_status_i), .ssc_o(slave_status_change_i),
        .tur_o(transport_ready_status_i));

    always @(posedge clk_i)
        if (transport_go_pulse_o === 1'b1)
            go_seen++;
    always @(negedge write_clock_gate_i)
        gate_fall = $time;

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input string msg);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : check

    function automatic logic [15:0] exp_fc(input logic [15:0] s, input int n);
        return s + 16'(n);
    endfunction : exp_fc

    function automatic logic pick(input int k);
        case (k)
            0: return reading_active_o;
            1: return end_of_record_pulse_o;
            2: return stop_o;
            3: return attention_request_o;
            4: return operation_incomplete_error_o;
            default: return !busy_o || stop_o;
        endcase
    endfunction : pick

    // Samples once per cycle, so one-cycle pulses are never missed.
    task automatic wait_for(input int k, input string msg);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < 3000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check(16'(n < 3000), 16'h0001, msg);
    endtask : wait_for

    task automatic start_op(input logic [2:0] op, input logic [1:0] mode,
        input logic rev);
        wait_for(5, "sequencer stays busy");
        op_i = op;
        rec_mode = mode;
        reverse_i = rev;
        run_request_i = op < 3'h2;
        go_request_i = op >= 3'h2;
        @(posedge clk_i);
        #1;
        run_request_i = 1'b0;
        go_request_i = 1'b0;
        check(16'({transport_go_pulse_o, motion_delay_load_o, stop_o}),
            16'h0006, "start pulses");
        check(16'({forward_command_o, reverse_command_o}),
            16'({!rev, rev} & {2{op != 3'h4}}), "direction");
    endtask : start_op

    initial
    begin
        #1200000;
        miscompares++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'hB3BA2DC2));
        repeat (5) @(posedge clk_i);
        #1;
        check(16'({stop_o, transport_go_pulse_o, motion_delay_load_o}),
            16'h0004, "reset state");
        rstn_i = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            unit_i = (i < 8) ? 3'(i) : 3'($urandom);
            #1;
            check(16'({transport_select_bit2_o, transport_select_bit1_o,
                transport_select_bit0_o}), 16'(unit_i), "select code");
        end
        unit_i = UNIT;
        repeat (2)
        begin
            start_op(3'h0, 2'h1, 1'($urandom));
            @(posedge clk_i);
            #1;
            run_request_i = 1'b1;
            @(posedge clk_i);
            #1;
            run_request_i = 1'b0;
            check(16'(transport_go_pulse_o), 16'h0000, "taken while busy");
            wait_for(0, "reading never active");
            check(16'(accelerating_flag_o), 16'h0000, "accelerating");
            wait_for(1, "no end of record");
            wait_for(2, "no stop after record");
            check(16'(accelerating_flag_o), 16'h0001, "flag at stop");
        end
        start_op(3'h1, 2'h1, 1'b0);
        wait_for(1, "no end of written record");
        check(16'($time - gate_fall >= GAP * 40), 16'h0001, "gap");
        wait_for(2, "no stop after write");
        start_op(3'h2, 2'h0, 1'b0);
        wait_for(1, "erase never ends");
        wait_for(3, "no erase attention");
        frame_count_i = 16'hFFFE;
        go_seen = 0;
        start_op(3'h3, 2'h1, 1'b0);
        wait_for(3, "no space attention");
        check(frame_count_o, exp_fc(16'hFFFE, 2), "frame count");
        check(16'(go_seen), 16'h0002, "restarts per record");
        frame_count_i = 16'($urandom_range(0, 16'hFF00));
        go_seen = 0;
        start_op(3'h3, 2'h2, 1'b0);
        wait_for(3, "no attention at tape mark");
        check(16'(go_seen), 16'h0001, "moved past tape mark");
        start_op(3'h4, 2'h0, 1'b0);
        check(16'(rewind_command_o), 16'h0001, "rewind line");
        @(posedge clk_i);
        #1;
        check(16'(stop_o), 16'h0001, "stop after rewind pulse");
        start_op(3'h0, 2'h0, 1'b0);
        t0 = $time;
        wait_for(4, "no incomplete flag");
        check(16'($time - t0 >= 1999 * 40), 16'h0001, "early timeout");
        wait_for(2, "no stop after timeout");
        give_verdict();
    end
endmodule : ttms_sequencer_bench
